// ===== core/idc_defs.svh
// idc_defs.svh - encodings, offsets, field positions and reset values of the decoder
// assumes: included by its bare name from the package and from the decoder
`ifndef IDC_DEFS_SVH
`define IDC_DEFS_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define IDC_PC_W        20
`define IDC_FA_W        12

// ----------------------------------------------------------------
// instruction encodings
// ----------------------------------------------------------------
`define IDC_NIB_SKIP0   4'hb
`define IDC_NIB_SKIP1   4'ha
`define IDC_NIB_BCLR    4'h9
`define IDC_NIB_BSET    4'h8
`define IDC_NIB_BINV    4'h7
`define IDC_NIB_COND    4'he
`define IDC_NIB_REL     4'hd
`define IDC_NIB_OPND    4'hf
`define IDC_HI_CALL     7'h76
`define IDC_HI_GOTO     8'hef
`define IDC_HI_RETLIT   8'h0c
`define IDC_W_NOP       16'h0000
`define IDC_W_STANDBY   16'h0003
`define IDC_W_WDT       16'h0004
`define IDC_W_PUSH      16'h0005
`define IDC_W_POP       16'h0006
`define IDC_W_DAW       16'h0007
`define IDC_W_RESET     16'h00ff
`define IDC_W_RETIRQ    15'h0008
`define IDC_W_RETSUB    15'h0009

// ----------------------------------------------------------------
// register offsets, fields, reset values
// ----------------------------------------------------------------
`define IDC_REG_CTRL    8'h00
`define IDC_REG_STAT    8'h04
`define IDC_REG_LAST    8'h08
`define IDC_CTRL_PSA    4
`define IDC_ST_TO       0
`define IDC_ST_PD       1
`define IDC_ST_GIE      2
`define IDC_ST_PERIPHERAL_IRQ_ENABLE     3
`define IDC_CTRL_RST    5'h00
`define IDC_STAT_RST    4'h3
`define IDC_ACCESS_BANK 4'h0

// ----------------------------------------------------------------
// decimal correction constants
// ----------------------------------------------------------------
`define IDC_BCD_LIMIT   4'h9
`define IDC_BCD_LO      9'h006
`define IDC_BCD_HI      9'h060

`endif

// ===== core/idc_pkg.sv
// idc_pkg.sv - types shared by the decoder and its bench
// assumes: idc_defs.svh reachable on the include path
package idc_pkg;
`include "idc_defs.svh"

	// ----------------------------------------------------------------
	// sequencing states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {IDC_EXEC, IDC_FLUSH, IDC_SKIP, IDC_OPERAND} idc_state_t;

	// alu flags seen by conditional jumps and decimal fix
	typedef struct packed {
		logic neg;
		logic ovf;
		logic zero;
		logic dcarry;
		logic carry;
	} idc_flags_t;

	// one cycle of decoded commands toward the core
	typedef struct packed {
		logic [`IDC_FA_W-1:0] file_addr;
		logic                 file_we;
		logic [7:0]           file_wdata;
		logic                 pc_load;
		logic [`IDC_PC_W-1:0] pc_target;
		logic                 stack_call;
		logic                 stack_push;
		logic                 stack_pop;
		logic                 stack_ret;
		logic                 shadow;
		logic                 wdt_restart;
		logic                 standby;
		logic                 sw_reset;
		logic                 acc_load;
		logic [7:0]           acc_data;
		logic                 carry_load;
		logic                 carry_val;
		logic                 prescaler_clear;
		logic                 nop_cycle;
	} idc_exec_t;

	// whole state of the decoder
	typedef struct packed {
		idc_state_t state;
		logic [8:0] first;
		idc_exec_t  ex;
		logic [4:0] ctrl;
		logic [3:0] stat;
		logic [31:0] rdata;
		logic [15:0] last;
		logic [7:0] pin_s1;
		logic [7:0] pin_s2;
		logic [7:0] pin_s3;
		logic [7:0] pins;
	} idc_regs_t;
endpackage

// ===== core/idc_decoder.sv
// idc_decoder.sv - bit and control instruction decoder of an 8-bit core
// assumes: one word per cycle with instr_valid_in; pc_in is the incremented
// word address; file_data_in answers the current word's file address
//
// Function
// RQ1 - upper nibble b: skip if bit zero
// RQ2 - upper nibble a: skip if bit one
// RQ3 - nibbles 9/8/7 clear, set, invert bit
// RQ4 - conditional relative jump on eight flag tests
// RQ5 - relative jump and relative call, two cycles
// RQ6 - two-word absolute call with shadow select
// RQ7 - two-word absolute jump, two cycles
// RQ8 - nibble f alone executes as no-operation
// RQ9 - pc change or true test adds idle cycle
// RQ10 - all-zero word is one-cycle no-operation
// RQ11 - watchdog restart updates timeout, power-down flags
// RQ12 - standby entry updates timeout, power-down flags
// RQ13 - software reset word resets whole device
// RQ14 - interrupt return re-enables both interrupt enables
// RQ15 - subroutine return, optional shadow restore
// RQ16 - literal return loads working accumulator
// RQ17 - push stack top entry
// RQ18 - discard stack top entry
// RQ19 - decimal fix of accumulator, carry only
// RQ20 - port read-modify-write uses pin levels
// RQ21 - timer zero write clears assigned prescaler
// RQ22 - operand bit a picks access or bank
// RQ23 - skipped word replaced by no-operation
// RQ24 - offsets are signed, added to incremented pc
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`include "idc_defs.svh"

module idc_decoder
	import idc_pkg::*;
(
	// clock and reset
	input  wire logic                 clk_in,
	input  wire logic                 rst_n_in,
	// instruction words from program memory
	input  wire logic                 instr_valid_in,
	input  wire logic [15:0]          instr_word_in,
	input  wire logic [`IDC_PC_W-1:0] pc_in,
	// operands from the core
	input  wire logic [7:0]           file_data_in,
	input  wire logic                 file_is_port_in,
	input  wire logic                 file_is_timer0_in,
	input  wire logic [7:0]           port_pins_in,
	input  wire logic [7:0]           working_accumulator_in,
	input  wire idc_flags_t           flags_in,
	// register port
	input  wire logic [7:0]           reg_addr_in,
	input  wire logic [31:0]          reg_wdata_in,
	input  wire logic                 reg_wr_in,
	input  wire logic                 reg_rd_in,
	output logic [31:0]               reg_rdata_out,
	// decoded commands
	output idc_exec_t                 exec_out,
	output logic                      watchdog_timeout_flag_out,
	output logic                      power_down_flag_out,
	output logic                      global_irq_enable_out,
	output logic                      peripheral_irq_enable_out
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	idc_regs_t r_q;   // all flops
	idc_regs_t r_d;   // next value

	// ----------------------------------------------------------------
	// word fields
	// ----------------------------------------------------------------
	logic [15:0] w;                      // current word
	logic [3:0]  nib;                    // upper nibble
	logic [2:0]  bsel;                   // bit number
	logic        in_exec;                // word is a fresh instruction
	logic [`IDC_FA_W-1:0] faddr;         // resolved file address
	logic [7:0]  src;                    // read-modify-write source
	logic        src_bit;                // tested bit
	logic [7:0]  bmask;                  // one-hot bit mask
	logic        cond_true;              // conditional jump outcome
	logic [4:0]  fsel;                   // flags in test order
	logic [`IDC_PC_W-1:0] tgt8;          // short relative target
	logic [`IDC_PC_W-1:0] tgt11;         // long relative target
	logic        two_word;               // word opens a two-word op
	logic [8:0]  bcd_lo;                 // decimal fix, low step
	logic [8:0]  bcd;                    // decimal fix result

	assign w       = instr_word_in;
	assign nib     = w[15:12];
	assign bsel    = w[11:9];
	assign in_exec = instr_valid_in && (r_q.state == IDC_EXEC);

	// access bank when a is clear, else the bank pointer
	assign faddr = w[8] ? {r_q.ctrl[3:0], w[7:0]}
	                    : {`IDC_ACCESS_BANK, w[7:0]};  // [RQ22]

	// ports are read from the pins so pulled-low inputs write back zero
	assign src     = file_is_port_in ? r_q.pins : file_data_in;  // [RQ20]
	assign bmask   = 8'h01 << bsel;
	assign src_bit = |(src & bmask);

	// ccc: pair picks the flag, low bit inverts it
	assign fsel      = {1'b0, flags_in.neg, flags_in.ovf, flags_in.carry, flags_in.zero};
	assign cond_true = fsel[w[10:9]] ^ w[8];  // [RQ4]

	// signed word offsets from the incremented pc
	assign tgt8  = pc_in + {{(`IDC_PC_W-8){w[7]}}, w[7:0]};     // [RQ24]
	assign tgt11 = pc_in + {{(`IDC_PC_W-11){w[10]}}, w[10:0]};  // [RQ24]

	// call and goto first words
	assign two_word = (w[15:9] == `IDC_HI_CALL) || (w[15:8] == `IDC_HI_GOTO);

	// decimal fix: low digit, then high digit with the carry
	assign bcd_lo = ((working_accumulator_in[3:0] > `IDC_BCD_LIMIT) || flags_in.dcarry)
	              ? ({1'b0, working_accumulator_in} + `IDC_BCD_LO)
	              : {1'b0, working_accumulator_in};
	assign bcd    = ((bcd_lo[7:4] > `IDC_BCD_LIMIT) || flags_in.carry || bcd_lo[8])
	              ? (bcd_lo + `IDC_BCD_HI) : bcd_lo;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		r_d       = r_q;
		r_d.ex    = '0;          // every command is a one-cycle pulse
		r_d.rdata = '0;          // unmapped and idle reads give zero

		// pin synchroniser: stage one feeds stage two only
		r_d.pin_s1 = port_pins_in;
		r_d.pin_s2 = r_q.pin_s1;
		r_d.pin_s3 = r_q.pin_s2;
		// a bit moves only once stages two and three agree
		r_d.pins = (r_q.pin_s2 & ~(r_q.pin_s2 ^ r_q.pin_s3))
		         | (r_q.pins & (r_q.pin_s2 ^ r_q.pin_s3));

		// register port reads
		if (reg_rd_in)
		begin
			unique case (reg_addr_in)
				`IDC_REG_CTRL: r_d.rdata = {27'h0, r_q.ctrl};
				`IDC_REG_STAT: r_d.rdata = {28'h0, r_q.stat};
				`IDC_REG_LAST: r_d.rdata = {16'h0, r_q.last};
				default:       r_d.rdata = '0;
			endcase
		end
		// register port writes; hardware updates below win
		if (reg_wr_in)
		begin
			if (reg_addr_in == `IDC_REG_CTRL)
				r_d.ctrl = reg_wdata_in[4:0];
			if (reg_addr_in == `IDC_REG_STAT)
				r_d.stat = reg_wdata_in[3:0];
		end

		if (instr_valid_in)
		begin
			r_d.last = w;
			unique case (r_q.state)
				// discarded word after a taken change of flow
				IDC_FLUSH:
				begin
					r_d.ex.nop_cycle = 1'b1;  // [RQ9]
					r_d.state        = IDC_EXEC;
				end
				// skipped word; a skipped two-word op costs one more
				IDC_SKIP:
				begin
					r_d.ex.nop_cycle = 1'b1;  // [RQ23]
					r_d.state        = two_word ? IDC_FLUSH : IDC_EXEC;  // [RQ1] [RQ2]
				end
				// operand word of call or goto
				IDC_OPERAND:
				begin
					r_d.ex.pc_load    = 1'b1;
					r_d.ex.pc_target  = {w[11:0], r_q.first[7:0]};  // [RQ6] [RQ7]
					r_d.ex.stack_call = ~r_q.first[8];              // [RQ6]
					r_d.state         = IDC_EXEC;
				end
				// fresh instruction
				IDC_EXEC:
				begin
					// skip tests
					if (nib == `IDC_NIB_SKIP0 || nib == `IDC_NIB_SKIP1)
					begin
						r_d.ex.file_addr = faddr;
						if (src_bit == (nib == `IDC_NIB_SKIP1))
							r_d.state = IDC_SKIP;  // [RQ1] [RQ2]
					end
					// bit clear, set, invert; flags untouched
					else if (nib == `IDC_NIB_BCLR || nib == `IDC_NIB_BSET
					         || nib == `IDC_NIB_BINV)
					begin
						r_d.ex.file_addr = faddr;
						r_d.ex.file_we   = 1'b1;
						unique case (nib)
							`IDC_NIB_BCLR: r_d.ex.file_wdata = src & ~bmask;  // [RQ3]
							`IDC_NIB_BSET: r_d.ex.file_wdata = src | bmask;   // [RQ3]
							default:       r_d.ex.file_wdata = src ^ bmask;   // [RQ3]
						endcase
						// timer zero write clears its prescaler if assigned
						r_d.ex.prescaler_clear = file_is_timer0_in
						                         & r_q.ctrl[`IDC_CTRL_PSA];  // [RQ21]
					end
					// conditional relative jumps
					else if (nib == `IDC_NIB_COND && !w[11])
					begin
						if (cond_true)
						begin
							r_d.ex.pc_load   = 1'b1;
							r_d.ex.pc_target = tgt8;  // [RQ4]
							r_d.state        = IDC_FLUSH;  // [RQ9]
						end
					end
					// relative jump and relative call
					else if (nib == `IDC_NIB_REL)
					begin
						r_d.ex.pc_load    = 1'b1;
						r_d.ex.pc_target  = tgt11;  // [RQ5]
						r_d.ex.stack_call = w[11];  // [RQ5]
						r_d.state         = IDC_FLUSH;  // [RQ9]
					end
					// first word of call or goto: hold the low address
					else if (two_word)
					begin
						r_d.first = {w[8] & w[9], w[7:0]};
						r_d.first[8] = (w[15:8] == `IDC_HI_GOTO);  // [RQ7]
						r_d.ex.shadow = (w[15:9] == `IDC_HI_CALL) & w[8];  // [RQ6]
						r_d.state = IDC_OPERAND;
					end
					// stray operand word runs as no-operation
					else if (nib == `IDC_NIB_OPND)
						r_d.ex.nop_cycle = 1'b1;  // [RQ8]
					// literal return
					else if (w[15:8] == `IDC_HI_RETLIT)
					begin
						r_d.ex.stack_ret = 1'b1;
						r_d.ex.acc_load  = 1'b1;
						r_d.ex.acc_data  = w[7:0];  // [RQ16]
						r_d.state        = IDC_FLUSH;  // [RQ9]
					end
					// interrupt return re-enables both enables
					else if (w[15:1] == `IDC_W_RETIRQ)
					begin
						r_d.ex.stack_ret = 1'b1;
						r_d.ex.shadow    = w[0];
						r_d.stat[`IDC_ST_GIE]  = 1'b1;  // [RQ14]
						r_d.stat[`IDC_ST_PERIPHERAL_IRQ_ENABLE] = 1'b1;  // [RQ14]
						r_d.state        = IDC_FLUSH;
					end
					// subroutine return, flags untouched
					else if (w[15:1] == `IDC_W_RETSUB)
					begin
						r_d.ex.stack_ret = 1'b1;
						r_d.ex.shadow    = w[0];  // [RQ15]
						r_d.state        = IDC_FLUSH;
					end
					else
					begin
						unique case (w)
							`IDC_W_WDT:
							begin
								r_d.ex.wdt_restart   = 1'b1;  // [RQ11]
								r_d.stat[`IDC_ST_TO] = 1'b1;
								r_d.stat[`IDC_ST_PD] = 1'b1;
							end
							`IDC_W_STANDBY:
							begin
								r_d.ex.standby       = 1'b1;  // [RQ12]
								r_d.stat[`IDC_ST_TO] = 1'b1;
								r_d.stat[`IDC_ST_PD] = 1'b0;
							end
							`IDC_W_RESET:
							begin
								r_d.ex.sw_reset = 1'b1;  // [RQ13]
								r_d.stat        = `IDC_STAT_RST;
								r_d.ctrl        = `IDC_CTRL_RST;
							end
							`IDC_W_PUSH: r_d.ex.stack_push = 1'b1;  // [RQ17]
							`IDC_W_POP:  r_d.ex.stack_pop  = 1'b1;  // [RQ18]
							`IDC_W_DAW:
							begin
								r_d.ex.acc_load   = 1'b1;  // [RQ19]
								r_d.ex.acc_data   = bcd[7:0];
								r_d.ex.carry_load = 1'b1;
								r_d.ex.carry_val  = bcd[8] | flags_in.carry;
							end
							// all-zero word and words outside this decoder
							default: r_d.ex.nop_cycle = 1'b1;  // [RQ10]
						endcase
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	// synchronous reset; a hazard here would be taking a port at reset
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			r_q       <= '0;
			r_q.state <= IDC_EXEC;
			r_q.ctrl  <= `IDC_CTRL_RST;
			r_q.stat  <= `IDC_STAT_RST;
		end
		else
			r_q <= r_d;
	end

	// outputs straight from the flops
	assign reg_rdata_out             = r_q.rdata;
	assign exec_out                  = r_q.ex;
	assign watchdog_timeout_flag_out = r_q.stat[`IDC_ST_TO];
	assign power_down_flag_out       = r_q.stat[`IDC_ST_PD];
	assign global_irq_enable_out     = r_q.stat[`IDC_ST_GIE];
	assign peripheral_irq_enable_out = r_q.stat[`IDC_ST_PERIPHERAL_IRQ_ENABLE];

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	// a taken skip replaces the next presented word by a no-operation;
	// a stall right after the skip only delays it, so it is not checked then
	sequence s_skip_zero;
		in_exec && nib == `IDC_NIB_SKIP0 && !src_bit ##1 instr_valid_in;
	endsequence
	sequence s_skipped;
		exec_out.nop_cycle && !exec_out.file_we;
	endsequence
	property p_skip_zero;
		s_skip_zero |=> s_skipped;
	endproperty
	a_skip_zero: assert property (p_skip_zero) else $error("zero skip lost"); // [RQ1]

	property p_skip_one;
		in_exec && nib == `IDC_NIB_SKIP1 && !src_bit |=> r_q.state == IDC_EXEC;
	endproperty
	a_skip_one: assert property (p_skip_one) else $error("false one skip"); // [RQ2]

	property p_bit_clear;
		in_exec && nib == `IDC_NIB_BCLR |=>
			exec_out.file_we && !exec_out.file_wdata[$past(bsel)];
	endproperty
	a_bit_clear: assert property (p_bit_clear) else $error("bit not cleared"); // [RQ3]

	property p_cond_taken;
		in_exec && nib == `IDC_NIB_COND && !w[11] && cond_true |=>
			exec_out.pc_load && exec_out.pc_target == $past(tgt8) && r_q.state == IDC_FLUSH;
	endproperty
	a_cond_taken: assert property (p_cond_taken) else $error("jump not taken"); // [RQ4]

	property p_rel_jump;
		in_exec && nib == `IDC_NIB_REL |=> exec_out.pc_load
			&& exec_out.pc_target == $past(pc_in) + {{9{$past(w[10])}}, $past(w[10:0])};
	endproperty
	a_rel_jump: assert property (p_rel_jump) else $error("bad relative target"); // [RQ5]

	sequence s_call_pair;
		in_exec && w[15:9] == `IDC_HI_CALL ##1 instr_valid_in;
	endsequence
	property p_call_two;
		s_call_pair |=> exec_out.pc_load && exec_out.stack_call;
	endproperty
	a_call_two: assert property (p_call_two) else $error("call not in two words"); // [RQ6]

	property p_operand_nop;
		in_exec && nib == `IDC_NIB_OPND |=> exec_out.nop_cycle && !exec_out.pc_load;
	endproperty
	a_operand_nop: assert property (p_operand_nop) else $error("stray operand acted"); // [RQ8]

	property p_watchdog;
		in_exec && w == `IDC_W_WDT |=> exec_out.wdt_restart
			&& watchdog_timeout_flag_out && power_down_flag_out;
	endproperty
	a_watchdog: assert property (p_watchdog) else $error("watchdog restart wrong"); // [RQ11]

	property p_irq_return;
		in_exec && w[15:1] == `IDC_W_RETIRQ |=> (global_irq_enable_out
			&& peripheral_irq_enable_out) and (instr_valid_in |=> exec_out.nop_cycle);
	endproperty
	a_irq_return: assert property (p_irq_return) else $error("irq return wrong"); // [RQ14]
endmodule

// ===== verif/idc_prog_mem.sv
// idc_prog_mem.sv - program memory model feeding the decoder one word a cycle
// assumes: bench fills mem and count_in, holds run_in high for one pass
`timescale 1ns/1ps

module idc_prog_mem
	import idc_pkg::*;
#(
	parameter logic [19:0] BASE = 20'h0fff0
)
(
	// clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	// pass control from the bench
	input  wire logic        run_in,
	input  wire logic        stall_in,
	input  wire logic [5:0]  count_in,
	// words toward the decoder
	output logic             valid_out,
	output logic [15:0]      word_out,
	output logic [19:0]      pc_out,
	output logic [5:0]       ptr_out,
	output logic             done_out
);
	logic [15:0] mem [0:63];  // program words

	initial
	begin
		valid_out = 1'b0;
		word_out = 16'h0000;
		pc_out = 20'h00000;
		ptr_out = 6'h00;
	end

	// pass over once every word was handed out
	assign done_out = run_in && ptr_out == count_in && !valid_out;

	// ----------
	// fetch
	// ----------
	// a stalled cycle inverts the word so a stale value never looks valid
	always @(posedge clk_in)
	begin
		if (!rst_n_in || !run_in)
		begin
			valid_out <= 1'b0;
			ptr_out <= 6'h00;
		end
		else if (!stall_in && ptr_out != count_in)
		begin
			valid_out <= 1'b1;
			word_out <= mem[ptr_out];
			pc_out <= BASE + 20'(ptr_out) + 20'h00001;
			ptr_out <= ptr_out + 6'h01;
		end
		else
		begin
			valid_out <= 1'b0;
			word_out <= ~word_out;
		end
	end
endmodule

// ===== verif/idc_decoder_test.sv
// idc_decoder_test.sv - self-checking bench of the bit and control decoder
// assumes: idc_pkg and idc_prog_mem compiled first
`timescale 1ns/1ps

module idc_decoder_test
	import idc_pkg::*;
;
	// ----------
	// signals
	// ----------
	logic        clk_in, rst_n_in, run, slow, stall, done, valid, chk_q;
	logic        wr, rd, psa, to, pd, global_irq_enable, peripheral_irq_enable;
	logic [5:0]  cnt, ptr, chk_i;
	logic [15:0] word, fw;
	logic [19:0] pc;
	logic [7:0]  raddr, pins, acc;
	logic [31:0] wdata, rdata, r, rs;
	logic [3:0]  bank_select_pointer;
	logic [1:0]  st;        // 0 run, 1 discard, 2 skip, 3 operand
	idc_flags_t  flg;
	idc_exec_t   ex;
	idc_exec_t   exp_e [0:63];
	idc_exec_t   exp_m [0:63];  // care mask per word
	integer      seed, err_count, tests_run, n, j;
	localparam logic [15:0] CORNER [0:20] = '{16'hb000, 16'he712, 16'hf345, 16'ha200,
		16'h0004, 16'h8e80, 16'h7081, 16'hd005, 16'hd802, 16'he205, 16'h0000, 16'he307,
		16'hef34, 16'hf123, 16'h0012, 16'h0013, 16'hd600, 16'h0000, 16'h0c77, 16'h0000, 16'hffff};
	localparam logic [7:0] DAWV [0:3] = '{8'h9a, 8'h45, 8'h0f, 8'h99};

	idc_decoder u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .instr_valid_in(valid),
		.instr_word_in(word), .pc_in(pc), .file_data_in(word[7:0] ^ 8'h5a),
		.file_is_port_in(word[7:0] == 8'h80), .file_is_timer0_in(word[7:0] == 8'h81),
		.port_pins_in(pins), .working_accumulator_in(acc), .flags_in(flg),
		.reg_addr_in(raddr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
		.reg_rdata_out(rdata), .exec_out(ex), .watchdog_timeout_flag_out(to),
		.power_down_flag_out(pd), .global_irq_enable_out(global_irq_enable),
		.peripheral_irq_enable_out(peripheral_irq_enable));
	idc_prog_mem u_mem (.clk_in(clk_in), .rst_n_in(rst_n_in), .run_in(run),
		.stall_in(stall), .count_in(cnt), .valid_out(valid), .word_out(word),
		.pc_out(pc), .ptr_out(ptr), .done_out(done));

	initial
	begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end

	// ----------
	// checks
	// ----------
	task automatic check_val(input logic [31:0] got, input logic [31:0] want);
		tests_run++;
		if (got !== want)
		begin
			err_count++;
			$display("BAD %0t value %h want %h", $time, got, want);
		end
	endtask

	task automatic check_ex(input int i);
		tests_run++;
		if ((ex & exp_m[i]) !== (exp_e[i] & exp_m[i]))
		begin
			err_count++;
			$display("BAD %0t word %0d exec %h want %h", $time, i, ex, exp_e[i]);
		end
	endtask

	task automatic test_done();
		if (err_count == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// exec answers one cycle after each taken word
	always @(posedge clk_in)
	begin
		chk_q <= valid;
		chk_i <= ptr - 6'h01;
	end
	always @(negedge clk_in)
		if (chk_q)
			check_ex(chk_i);

	// slow partner: random gaps only while a pass asks for them
	always @(posedge clk_in)
		if (slow)
		begin
			rs = $random(seed);
			stall <= rs[0];
		end
		else
			stall <= 1'b0;

	// ----------
	// register port
	// ----------
	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		raddr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_in);
		wr <= 1'b0;
	endtask

	task automatic reg_read(input logic [7:0] a, input logic [31:0] want);
		@(posedge clk_in);
		raddr <= a;
		rd <= 1'b1;
		@(posedge clk_in);
		rd <= 1'b0;
		@(negedge clk_in);
		check_val(rdata, want);
	endtask

	// ----------
	// expectation per word, walking the word stream in order
	// ----------
	task automatic expect_word(input logic [15:0] w, input logic [19:0] p, input int k);
		idc_exec_t  e;
		idc_exec_t  m;
		logic [8:0] t;
		logic [7:0] src;
		logic       tk;
		e = '0;
		m = '1;
		{m.nop_cycle, m.file_addr, m.file_wdata, m.pc_target, m.acc_data, m.carry_val} = '0;
		src = (w[7:0] == 8'h80) ? pins : (w[7:0] ^ 8'h5a);
		tk = ((w[10:9] == 2'd0) ? flg.zero : (w[10:9] == 2'd1) ? flg.carry :
			(w[10:9] == 2'd2) ? flg.ovf : flg.neg) ^ w[8];
		if (st == 2'd1 || st == 2'd2)
		begin
			{e.nop_cycle, m.nop_cycle} = 2'b11;
			st = (st == 2'd2 && (w[15:9] == 7'h76 || w[15:8] == 8'hef)) ? 2'd1 : 2'd0;
		end
		else if (st == 2'd3)
		begin
			{e.pc_load, e.pc_target, m.pc_target} = {1'b1, w[11:0], fw[7:0], 20'hfffff};
			e.stack_call = fw[15:8] != 8'hef;
			st = 2'd0;
		end
		else
			case (w[15:12])
				4'hb, 4'ha: st = (src[w[11:9]] == (w[15:12] == 4'ha)) ? 2'd2 : 2'd0;
				4'h9, 4'h8, 4'h7:
				begin
					e.file_we = 1'b1;
					e.file_addr = {(w[8] ? bank_select_pointer : 4'h0), w[7:0]};
					e.file_wdata = (!w[15] ? src ^ (8'h01 << w[11:9]) : w[12] ? src & ~(8'h01 <<
						w[11:9]) : src | (8'h01 << w[11:9]));
					e.prescaler_clear = (w[7:0] == 8'h81) && psa;
					{m.file_addr, m.file_wdata} = '1;
				end
				4'he:
				begin
					if (!w[11] && tk)
						{e.pc_load, e.pc_target, st} = {1'b1, p + {{12{w[7]}}, w[7:0]}, 2'd1};
					if (w[11])
						{e.shadow, fw, st} = {~w[9] & w[8], w, 2'd3};
					m.pc_target = '1;
				end
				4'hd:
				begin
					{e.pc_load, e.pc_target, st} = {1'b1, p + {{9{w[10]}}, w[10:0]}, 2'd1};
					{e.stack_call, m.pc_target} = {w[11], 20'hfffff};
				end
				4'h0:
					if (w[15:8] == 8'h0c)
						{e.stack_ret, e.acc_load, e.acc_data, m.acc_data, m.pc_load, st} =
							{2'b11, w[7:0], 8'hff, 1'b0, 2'd1};
					else if (w[15:2] == 14'h0004)
						{e.stack_ret, e.shadow, m.pc_load, st} = {1'b1, w[0], 1'b0, 2'd1};
					else if (w == 16'h0007)
					begin
						t = {1'b0, acc};
						if (acc[3:0] > 4'h9 || flg.dcarry)
							t = t + 9'h006;
						if (t[7:4] > 4'h9 || t[8] || flg.carry)
							t = t + 9'h060;
						{e.acc_load, e.acc_data, e.carry_load, e.carry_val} = {1'b1, t[7:0], 1'b1, t[8]};
						{m.acc_data, m.carry_val} = {8'hff, !flg.carry};
					end
					else
					begin
						e.standby = w == 16'h0003;
						e.wdt_restart = w == 16'h0004;
						e.stack_push = w == 16'h0005;
						e.stack_pop = w == 16'h0006;
						e.sw_reset = w == 16'h00ff;
					end
				default: e = '0;
			endcase
		exp_e[k] = e;
		exp_m[k] = m;
	endtask

	task automatic gen_word();
		logic [31:0] q;
		logic [15:0] w;
		r = $random(seed);
		q = $random(seed);
		case (q[3:0] % 4'hc)
			4'h0: w = {4'hb, r[11:8], 1'b0, r[6:0]};
			4'h1: w = {4'ha, r[11:8], 1'b0, r[6:0]};
			4'h2: w = {(r[13] ? 4'h7 : (r[12] ? 4'h8 : 4'h9)), r[11:8], 1'b0, r[6:0]};
			4'h3, 4'h4: w = {5'h1c, r[10:0]};
			4'h5: w = {4'hd, r[11:0]};
			4'h6: w = {7'h76, r[8:0]};
			4'h7: w = {8'hef, r[7:0]};
			4'h8: w = {4'hf, r[11:0]};
			4'h9: w = r[4] ? {14'h0004, r[1:0]} : 16'h0003 + 16'(r[2:0] % 3'h5);
			4'ha: w = {8'h0c, r[7:0]};
			default: w = 16'h0000;
		endcase
		u_mem.mem[n] = w;
		n++;
		if (w[15:9] == 7'h76 || w[15:8] == 8'hef)
		begin
			u_mem.mem[n] = {4'hf, q[27:16]};
			n++;
		end
	endtask

	task automatic run_prog(input logic s);
		int k;
		// st carries over: the decoder keeps its state between passes
		for (k = 0; k < n; k++)
			expect_word(u_mem.mem[k], 20'h0fff0 + 20'(k) + 20'h00001, k);
		@(posedge clk_in);
		{cnt, slow, run} <= {6'(n), s, 1'b1};
		for (k = 0; k < 300 && !done; k++)
			@(posedge clk_in);
		check_val({31'h0, done}, 32'h1);
		repeat (2) @(posedge clk_in);
		{run, slow} <= 2'b00;
		n = 0;
		@(negedge clk_in);
	endtask

	// ----------
	// main sequence
	// ----------
	initial
	begin
		{seed, err_count, tests_run, n} = {32'd99657, 96'd0};
		{rst_n_in, run, slow, wr, rd, psa, raddr, wdata, cnt, pins, acc, bank_select_pointer, flg, st} = '0;
		repeat (16) @(posedge clk_in);
		rst_n_in <= 1'b1;
		reg_read(8'h04, 32'h3);
		reg_read(8'h0c, 32'h0);
		// random passes: flags, bank, pins and accumulator change each pass
		for (j = 0; j < 6; j++)
		begin
			r = $random(seed);
			{psa, bank_select_pointer, pins, acc, flg} <= r[25:0];
			reg_write(8'h00, {27'h0, r[25:21]});
			reg_read(8'h00, {27'h0, r[25:21]});
			while (n < 56)
				gen_word();
			run_prog(j[0]);
		end
		// hand-picked corners, partner stalling at random; decimal fix values without stalls
		{flg, pins, psa, bank_select_pointer} <= {5'h01, 8'h35, 5'h13};
		reg_write(8'h00, 32'h13);
		for (n = 0; n < 21; n++)
			u_mem.mem[n] = CORNER[n];
		run_prog(1'b1);
		for (j = 0; j < 4; j++)
		begin
			{acc, flg} <= {DAWV[j], 5'h00};
			{u_mem.mem[0], n} = {16'h0007, 32'd1};
			@(posedge clk_in);
			run_prog(1'b0);
		end
		// status flags through interrupt return, standby, watchdog, software reset
		{u_mem.mem[0], u_mem.mem[1], u_mem.mem[2], n} = {48'h0011_0000_0003, 32'd3};
		run_prog(1'b0);
		check_val({28'h0, peripheral_irq_enable, global_irq_enable, pd, to}, 32'hd);
		reg_read(8'h04, 32'hd);
		{u_mem.mem[0], n} = {16'h0004, 32'd1};
		run_prog(1'b0);
		reg_read(8'h04, 32'hf);
		{u_mem.mem[0], n} = {16'h00ff, 32'd1};
		run_prog(1'b0);
		reg_read(8'h04, 32'h3);
		reg_read(8'h00, 32'h0);
		reg_read(8'h08, 32'h00ff);
		test_done();
	end

	// hang guard, well beyond the longest expected run
	initial
	begin
		repeat (20000) @(posedge clk_in);
		err_count++;
		test_done();
	end
endmodule
